/* i2c_line_control_and_mode_tb.sv */
// Self-checking bench for ilc_top
`timescale 1ns/100ps
`default_nettype none
`include "ilc_defs.vh"
module i2c_line_control_and_mode_tb;
  // Short half period keeps transfers brief
  localparam int HC = 4;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, clr = 1'h1, ack_en = 1'h1;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, scl_o, scl_oe, sda_o, sda_oe;
  logic        scl_ln, sda_ln;
  logic [7:0]  got;
  int          fail_count, comparisons, run, maxrun;
  ilc_top #(.HALF_CYC(HC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_ln), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_ln), .sda_o(sda_o), .sda_oe(sda_oe));
  ilc_peer peer (
    .pclk(pclk), .clr(clr), .ack_en(ack_en), .scl_oe(scl_oe),
    .sda_oe(sda_oe), .scl_ln(scl_ln), .sda_ln(sda_ln), .got(got));
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    run <= scl_oe ? run + 1 : 0;
    if (clr)
      maxrun <= 0;
    else if (run > maxrun)
      maxrun <= run;
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] mode, ctl, d);
    clr <= 1'h1;
    apb(1'h1, `ILC_OFS_MODE, mode);
    apb(1'h1, `ILC_OFS_DATA, d);
    clr <= 1'h0;
    apb(1'h1, `ILC_OFS_CTRL, ctl);
    rd = 32'h4;
    repeat (200) if (rd[2]) apb(1'h0, `ILC_OFS_CTRL, 8'h0);
    chk({7'h0, rd[2]}, 8'h0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `ILC_OFS_LINE, 8'h0);
    chk(rd[7:0], 8'h3d);
    apb(1'h0, `ILC_OFS_MODE, 8'h0);
    chk(rd[7:0], 8'h00);
    apb(1'h1, `ILC_OFS_LINE, 8'h00);
    apb(1'h0, `ILC_OFS_LINE, 8'h0);
    chk(rd[7:0], 8'h1d);
    chk({7'h0, sda_oe}, 8'h1);
    apb(1'h1, `ILC_OFS_LINE, 8'h30);
    apb(1'h0, `ILC_OFS_LINE, 8'h0);
    chk(rd[7:0], 8'h1d);
    apb(1'h1, `ILC_OFS_LINE, 8'h20);
    apb(1'h0, `ILC_OFS_LINE, 8'h0);
    chk({sda_oe, rd[6:0]}, 8'h3d);
    apb(1'h0, 12'h010, 8'h0);
    chk({err, rd[6:0]}, 8'h80);
    // Master: two-wire MSB first, then two-wire with wait, then sync LSB first
    xfer(8'h00, 8'h05, 8'ha5);
    chk(got, 8'ha5);
    chk({rd[3], 6'h0, maxrun > 2 * HC}, 8'h80);
    xfer(8'h40, 8'h05, 8'h5a);
    chk({6'h0, maxrun > 4 * HC, maxrun > 5 * HC + 2}, 8'h2);
    ack_en <= 1'h0;
    xfer(8'hc0, 8'h07, 8'h31);
    chk(got, 8'h8c);
    chk({7'h0, maxrun > 2 * HC}, 8'h0);
    // Slave with wait set never pulls SCL; it waits on the far clock
    clr <= 1'h1;
    apb(1'h1, `ILC_OFS_MODE, 8'h40);
    clr <= 1'h0;
    apb(1'h1, `ILC_OFS_CTRL, 8'h04);
    repeat (40) @(posedge pclk);
    apb(1'h0, `ILC_OFS_CTRL, 8'h0);
    chk({6'h0, rd[2], maxrun > 0}, 8'h2);
    // Control-part reset in mid-transfer keeps registers
    apb(1'h1, `ILC_OFS_MODE, 8'h40);
    apb(1'h1, `ILC_OFS_CTRL, 8'h05);
    repeat (20) @(posedge pclk);
    apb(1'h1, `ILC_OFS_LINE, 8'h32);
    apb(1'h0, `ILC_OFS_CTRL, 8'h0);
    chk({rd[2], scl_oe, sda_oe}, 8'h0);
    apb(1'h0, `ILC_OFS_LINE, 8'h0);
    chk(rd[7:0], 8'h3f);
    apb(1'h0, `ILC_OFS_MODE, 8'h0);
    chk(rd[7:0], 8'h40);
    apb(1'h1, `ILC_OFS_LINE, 8'h30);
    apb(1'h0, `ILC_OFS_LINE, 8'h0);
    chk(rd[7:0], 8'h3d);
    give_verdict();
  end
endmodule // i2c_line_control_and_mode_tb
`default_nettype wire

/* ilc_defs.vh */
// Register map, field positions, reset values and timing for ilc_top
`ifndef ILC_DEFS_VH
`define ILC_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ILC_OFS_LINE      12'h000
`define ILC_OFS_MODE      12'h004
`define ILC_OFS_CTRL      12'h008
`define ILC_OFS_DATA      12'h00c

// ----------------------------------------------------------------
// Line control fields
// ----------------------------------------------------------------
`define ILC_LINE_SDA      5
`define ILC_LINE_GUARD    4
`define ILC_LINE_SCLMON   3
`define ILC_LINE_RSV2     2
`define ILC_LINE_CRST     1
`define ILC_LINE_RSV0     0
`define ILC_SDA_RST       1'b1
`define ILC_CRST_RST      1'b0

// ----------------------------------------------------------------
// Bus mode fields
// ----------------------------------------------------------------
`define ILC_MODE_ORDER    7
`define ILC_MODE_WAIT     6
`define ILC_ORDER_RST     1'b0
`define ILC_WAIT_RST      1'b0

// ----------------------------------------------------------------
// Transfer control fields
// ----------------------------------------------------------------
`define ILC_CTRL_MASTER   0
`define ILC_CTRL_SYNC     1
`define ILC_CTRL_GO       2
`define ILC_CTRL_ACK      3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ILC_CLK_NS        5
`define ILC_HALF_NS       5000
`define ILC_HALF_CYC      (`ILC_HALF_NS / `ILC_CLK_NS)
`define ILC_WAIT_CLOCKS   2

`endif

/* ilc_peer.sv */
// Far-side two-wire device: pull-ups, receiver, acknowledge
`timescale 1ns/100ps
`default_nettype none
module ilc_peer (
  // Control
  input wire logic  pclk,
  input wire logic  clr,
  input wire logic  ack_en,
  // Lines
  input wire logic  scl_oe,
  input wire logic  sda_oe,
  output logic      scl_ln,
  output logic      sda_ln,
  output logic [7:0] got
);
  logic [3:0] rises;
  logic       ack_reg;
  logic       scl_d;
  // Released lines go high through the pull-ups
  assign scl_ln = !scl_oe;
  assign sda_ln = !(sda_oe || ack_reg);
  always @(posedge pclk) begin
    scl_d <= scl_ln;
    if (clr) begin
      rises <= 4'h0;
      ack_reg <= 1'h0;
      got <= 8'h0;
    end else if (scl_ln && !scl_d) begin
      if (rises < 4'h8)
        got <= {got[6:0], sda_ln};
      rises <= rises + 4'h1;
    end else if (!scl_ln && scl_d)
      ack_reg <= ack_en && rises == 4'h8;
  end
endmodule // ilc_peer
`default_nettype wire

/* ilc_properties.sv */
// Checker on the ilc_top ports
`timescale 1ns/100ps
`default_nettype none
`include "ilc_defs.vh"
module ilc_checker #(
  parameter HALF_CYC = 4
) (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  logic [15:0] low_run;
  wire ln = paddr == `ILC_OFS_LINE;
  wire rd_ln = pready && !pwrite && ln;
  wire wr_ln = pready && pwrite && ln;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Low half plus the four-half wait, with slack for pin lag
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      low_run <= 16'h0;
    else
      low_run <= scl_oe ? low_run + 16'h1 : 16'h0;
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_unmapped: assert property (pready && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > `ILC_OFS_DATA)) else $error("pslverr wrong");
  a_fixed_ones: assert property (
    rd_ln |-> {prdata[4], prdata[2], prdata[0]} == 3'h7)
    else $error("fixed bits not 1");
  a_scl_monitor: assert property (
    rd_ln && $stable(scl_oe) |-> prdata[3] == !scl_oe)
    else $error("scl monitor wrong");
  a_open_drain: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  a_sda_low: assert property (
    wr_ln && pwdata[5:4] == 2'h0 |-> ##2 sda_oe)
    else $error("sda not low");
  a_guard_hold: assert property (
    wr_ln && pwdata[4] && !pwdata[1] && !scl_oe |=> $stable(sda_oe) [*3])
    else $error("guarded write moved sda");
  a_scl_low_max: assert property (
    low_run <= 5 * HALF_CYC + 2) else $error("scl low too long");
  c_line_read: cover property (rd_ln);
  c_wait_seen: cover property (low_run > 4 * HALF_CYC);
  c_guard_write: cover property (wr_ln && pwdata[4]);
endmodule // ilc_checker

bind ilc_top ilc_checker #(.HALF_CYC(HALF_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

/* ilc_top.v */
// Two-wire line control, bus mode register and small transfer engine
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ilc_defs.vh"

module ilc_top #(
  parameter HALF_CYC = `ILC_HALF_CYC
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Two-wire pins
  input  wire        scl_i,
  output reg         scl_o,
  output reg         scl_oe,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe
);

  // ----------------------------------------------------------------
  // States and helpers
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_LOW  = 2'd1;
  localparam [1:0] ST_HIGH = 2'd2;
  localparam [1:0] ST_WAIT = 2'd3;
  // Full-width sums first, then cut to the counter widths on purpose
  localparam integer HALF_M1  = HALF_CYC - 1;
  localparam integer WAIT_SUM = 2 * `ILC_WAIT_CLOCKS;
  localparam [15:0] HALF_LAST = HALF_M1[15:0];
  // Two transfer clocks are four half periods
  localparam [2:0] WAIT_HALVES = WAIT_SUM[2:0];

  // Shift position of transfer bit n under the selected order
  function [2:0] bit_index;
    input [3:0] n;
    input       lsb_first;
    begin
      bit_index = lsb_first ? n[2:0] : (3'd7 - n[2:0]);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg       scl_last_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_last_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_last_reg <= scl_sync_reg[1];
    end
  end

  wire scl_in = scl_sync_reg[1];
  wire sda_in = sda_sync_reg[1];
  wire scl_rise = scl_in & ~scl_last_reg;
  wire scl_fall = ~scl_in & scl_last_reg;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg        sda_out_level_reg;
  reg        ctrl_part_reset_reg;
  reg        bit_order_select_reg;
  reg        wait_enable_reg;
  reg        master_mode_reg;
  reg        sync_format_reg;
  reg  [7:0] tx_data_reg;
  reg  [7:0] rx_data_reg;
  reg        ack_seen_reg;
  reg  [1:0] state_reg;
  reg        go_reg;


  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire setup    = psel & ~penable;
  wire wr_fire  = psel & penable & pready & pwrite;
  wire busy     = (state_reg != ST_IDLE) | go_reg;
  wire addr_ok  = (paddr == `ILC_OFS_LINE) | (paddr == `ILC_OFS_MODE) |
                  (paddr == `ILC_OFS_CTRL) | (paddr == `ILC_OFS_DATA);


  // ----------------------------------------------------------------
  // Register bus read path
  // ----------------------------------------------------------------
  // Read data is formed in the setup cycle so prdata is a flop output
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0000_0000;
    case (paddr)
      `ILC_OFS_LINE: begin
        rd_next[`ILC_LINE_SDA]    = sda_out_level_reg;
        rd_next[`ILC_LINE_GUARD]  = 1'b1;
        rd_next[`ILC_LINE_SCLMON] = ~scl_oe;
        rd_next[`ILC_LINE_RSV2]   = 1'b1;
        rd_next[`ILC_LINE_CRST]   = ctrl_part_reset_reg;
        rd_next[`ILC_LINE_RSV0]   = 1'b1;
      end
      `ILC_OFS_MODE: begin
        rd_next[`ILC_MODE_ORDER] = bit_order_select_reg;
        rd_next[`ILC_MODE_WAIT]  = wait_enable_reg;
      end
      `ILC_OFS_CTRL: begin
        rd_next[`ILC_CTRL_MASTER] = master_mode_reg;
        rd_next[`ILC_CTRL_SYNC]   = sync_format_reg;
        rd_next[`ILC_CTRL_GO]     = busy;
        rd_next[`ILC_CTRL_ACK]    = ack_seen_reg;
      end
      `ILC_OFS_DATA: begin
        rd_next[7:0] = rx_data_reg;
      end
      default: begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end


  // ----------------------------------------------------------------
  // Register bus answer
  // ----------------------------------------------------------------
  // No wait state: pready rises in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_ok;
      if (setup && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end


  // ----------------------------------------------------------------
  // Register bus write path
  // ----------------------------------------------------------------
  // Software-written fields; the control-part reset never touches these
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_out_level_reg    <= `ILC_SDA_RST;
      ctrl_part_reset_reg  <= `ILC_CRST_RST;
      bit_order_select_reg <= `ILC_ORDER_RST;
      wait_enable_reg      <= `ILC_WAIT_RST;
      master_mode_reg      <= 1'b0;
      sync_format_reg      <= 1'b0;
      tx_data_reg          <= 8'h00;
    end else if (wr_fire) begin
      case (paddr)
        `ILC_OFS_LINE: begin
          // Guard bit written as 1 blocks the level update
          if (!pwdata[`ILC_LINE_GUARD]) begin
            sda_out_level_reg <= pwdata[`ILC_LINE_SDA];
          end
          ctrl_part_reset_reg <= pwdata[`ILC_LINE_CRST];
        end
        `ILC_OFS_MODE: begin
          bit_order_select_reg <= pwdata[`ILC_MODE_ORDER];
          wait_enable_reg      <= pwdata[`ILC_MODE_WAIT];
        end
        `ILC_OFS_CTRL: begin
          master_mode_reg <= pwdata[`ILC_CTRL_MASTER];
          sync_format_reg <= pwdata[`ILC_CTRL_SYNC];
        end
        `ILC_OFS_DATA: begin
          tx_data_reg <= pwdata[7:0];
        end
        default: begin
          tx_data_reg <= tx_data_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  // A master times each half period itself; a slave follows SCL edges
  reg [15:0] half_cnt_reg;
  reg  [3:0] bit_cnt_reg;
  reg  [2:0] wait_cnt_reg;
  reg        scl_low_reg;
  reg        sda_drv_reg;


  // ----------------------------------------------------------------
  // Engine decode
  // ----------------------------------------------------------------
  wire half_done = (half_cnt_reg == HALF_LAST);
  wire low_end   = master_mode_reg ? half_done : scl_rise;
  wire high_end  = master_mode_reg ? half_done : scl_fall;
  wire [3:0] last_bit = sync_format_reg ? 4'd7 : 4'd8;
  wire is_ack    = ~sync_format_reg & (bit_cnt_reg == 4'd8);
  // Wait applies only to a two-wire master
  wire use_wait  = wait_enable_reg & master_mode_reg &
                   ~sync_format_reg;
  wire [2:0] tx_pos = bit_index(bit_cnt_reg, bit_order_select_reg);

  // ----------------------------------------------------------------
  // Engine state machine
  // ----------------------------------------------------------------

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_IDLE;
      go_reg       <= 1'b0;
      half_cnt_reg <= 16'h0000;
      bit_cnt_reg  <= 4'h0;
      wait_cnt_reg <= 3'h0;
      rx_data_reg  <= 8'h00;
      ack_seen_reg <= 1'b0;
      scl_low_reg  <= 1'b0;
      sda_drv_reg  <= 1'b1;
    end else if (ctrl_part_reset_reg) begin
      // Clears a hung transfer while register settings stay put
      state_reg    <= ST_IDLE;
      go_reg       <= 1'b0;
      half_cnt_reg <= 16'h0000;
      bit_cnt_reg  <= 4'h0;
      wait_cnt_reg <= 3'h0;
      scl_low_reg  <= 1'b0;
      sda_drv_reg  <= 1'b1;
    end else begin
      if (wr_fire && paddr == `ILC_OFS_CTRL && pwdata[`ILC_CTRL_GO]) begin
        go_reg <= 1'b1;
      end
      half_cnt_reg <= half_done ? 16'h0000 : half_cnt_reg + 16'h0001;
      case (state_reg)
        ST_IDLE: begin
          half_cnt_reg <= 16'h0000;
          if (go_reg) begin
            go_reg      <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= ST_LOW;
            scl_low_reg <= master_mode_reg;
          end
        end
        ST_LOW: begin
          sda_drv_reg <= is_ack ? 1'b1 : tx_data_reg[tx_pos];
          if (low_end) begin
            scl_low_reg <= 1'b0;
            state_reg   <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (high_end) begin
            if (is_ack) begin
              ack_seen_reg <= ~sda_in;
            end else begin
              rx_data_reg[tx_pos] <= sda_in;
            end
            if (bit_cnt_reg == last_bit) begin
              state_reg   <= ST_IDLE;
              sda_drv_reg <= 1'b1;
            end else if (bit_cnt_reg == 4'd7 && use_wait) begin
              // Extra low time after the final data bit
              state_reg    <= ST_WAIT;
              wait_cnt_reg <= 3'h0;
              scl_low_reg  <= 1'b1;
            end else begin
              // No wait: the next bit, or the acknowledge after bit 7, follows at once
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              state_reg   <= ST_LOW;
              scl_low_reg <= master_mode_reg;
            end
          end
        end
        ST_WAIT: begin
          if (half_done) begin
            wait_cnt_reg <= wait_cnt_reg + 3'h1;
            if (wait_cnt_reg == WAIT_HALVES - 3'h1) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              state_reg   <= ST_LOW;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Both lines are open drain: only a low is ever driven
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o  <= 1'b0;
      scl_oe <= scl_low_reg;
      sda_o  <= 1'b0;
      if (state_reg == ST_IDLE) begin
        sda_oe <= ~sda_out_level_reg;
      end else begin
        sda_oe <= ~sda_drv_reg;
      end
    end
  end

endmodule // ilc_top

`default_nettype wire
